// [logic/dcfl_decode.sv]
`timescale 1ns/1ps
module dcfl_decode
    import dcfl_pkg::*;
(
    input wire logic [31:0] instr,
    input wire logic [31:0] base_operand_register,
    output logic is_flush,
    output logic [31:0] eff_addr
);
    import dcfl_pkg::*;

    logic [OFFSET_W-1:0] signed_offset_field;

    always_comb begin
        signed_offset_field = instr[OFFSET_LSB +: OFFSET_W];
        is_flush = (instr[OPC_LSB +: 6] == OPC_FLUSH_LINE);
        // Base plus sign-extended offset
        eff_addr = base_operand_register
            + {{(32 - OFFSET_W){signed_offset_field[OFFSET_W-1]}}, signed_offset_field};
    end
endmodule

// [logic/dcfl_pkg.sv]
package dcfl_pkg;
    // ----------------------------------------
    // Instruction layout
    // ----------------------------------------
    localparam logic [5:0] OPC_FLUSH_LINE = 6'h3b;
    localparam int OPC_LSB = 0;
    localparam int OFFSET_LSB = 6;
    localparam int BASE_LSB = 27;
    localparam int OFFSET_W = 16;

    // ----------------------------------------
    // Cache geometry defaults
    // ----------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LINE_IDX_W = 6;
    localparam int WORD_IDX_W = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic RST_VALID = 1'b0;
    localparam logic RST_DIRTY = 1'b0;

    typedef enum logic [1:0] {
        DCFL_IDLE = 2'b00,
        DCFL_WBACK = 2'b01,
        DCFL_INVAL = 2'b10
    } dcfl_state_e;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] base_operand_register;
    } dcfl_issue_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } dcfl_mem_wr_s;

    typedef struct packed {
        logic wr;
        logic [LINE_IDX_W-1:0] line;
        logic [WORD_IDX_W-1:0] word;
        logic [DATA_W-1:0] data;
    } dcfl_store_s;
endpackage

// [logic/dcfl_top.sv]
`timescale 1ns/1ps
module dcfl_top
    import dcfl_pkg::*;
#(
    parameter bit HAS_DCACHE = 1'b1,
    parameter int LINE_W = LINE_IDX_W,
    parameter int WORD_W = WORD_IDX_W
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire dcfl_pkg::dcfl_issue_s issue,
    input wire dcfl_pkg::dcfl_store_s store,
    input wire logic [ADDR_W-LINE_W-WORD_W-3:0] fill_tag,
    input wire logic fill_en,
    input wire logic [LINE_W-1:0] fill_line,
    output logic stall,
    output logic done,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output dcfl_pkg::dcfl_mem_wr_s mem_wr,
    output logic line_valid_rd,
    output logic line_dirty_rd
);
    import dcfl_pkg::*;

    localparam int LINES = 1 << LINE_W;
    localparam int WORDS = 1 << WORD_W;
    localparam int TAG_W = ADDR_W - LINE_W - WORD_W - 2;

    // ----------------------------------------
    // Line storage (direct mapped)
    // ----------------------------------------
    logic [DATA_W-1:0] mem_data [LINES*WORDS];
    logic [TAG_W-1:0] tag [LINES];
    logic [LINES-1:0] valid;
    logic [LINES-1:0] dirty;
    logic [LINES-1:0] next_valid;
    logic [LINES-1:0] next_dirty;

    logic is_flush;
    logic [31:0] eff_addr;

    dcfl_decode u_dec (
        .instr(issue.instr),
        .base_operand_register(issue.base_operand_register),
        .is_flush(is_flush),
        .eff_addr(eff_addr)
    );

    function automatic logic [LINE_W-1:0] line_of(input logic [31:0] a);
        line_of = a[2+WORD_W +: LINE_W];
    endfunction

    // ----------------------------------------
    // Flush sequencer
    // ----------------------------------------
    dcfl_state_e state;
    dcfl_state_e next_state;
    logic [LINE_W-1:0] sel;
    logic [LINE_W-1:0] next_sel;
    logic [WORD_W-1:0] wcnt;
    logic [WORD_W-1:0] next_wcnt;
    logic next_mem_wr_valid;
    dcfl_mem_wr_s next_mem_wr;
    logic next_done;
    logic start;

    assign start = issue.valid && is_flush && state == DCFL_IDLE;

    always_comb begin
        next_state = state;
        next_sel = sel;
        next_wcnt = wcnt;
        next_mem_wr_valid = mem_wr_valid;
        next_mem_wr = mem_wr;
        next_done = 1'b0;
        unique case (state)
            DCFL_IDLE: begin
                if (start) begin
                    next_sel = line_of(eff_addr);
                    next_wcnt = '0;
                    if (!HAS_DCACHE) begin
                        next_done = 1'b1;
                    end else if (dirty[line_of(eff_addr)]) begin
                        next_state = DCFL_WBACK;
                        next_mem_wr_valid = 1'b1;
                        next_mem_wr.addr = {tag[line_of(eff_addr)], line_of(eff_addr),
                            {WORD_W{1'b0}}, 2'b00};
                        next_mem_wr.data = mem_data[{line_of(eff_addr), {WORD_W{1'b0}}}];
                    end else begin
                        next_state = DCFL_INVAL;
                    end
                end
            end
            DCFL_WBACK: begin
                if (mem_wr_ready) begin
                    if (wcnt == WORD_W'(WORDS - 1)) begin
                        next_mem_wr_valid = 1'b0;
                        next_state = DCFL_INVAL;
                    end else begin
                        next_wcnt = wcnt + 1'b1;
                        next_mem_wr.addr = {tag[sel], sel, WORD_W'(wcnt + 1'b1), 2'b00};
                        next_mem_wr.data = mem_data[{sel, WORD_W'(wcnt + 1'b1)}];
                    end
                end
            end
            DCFL_INVAL: begin
                next_state = DCFL_IDLE;
                next_done = 1'b1;
            end
            default: begin
                next_state = DCFL_IDLE;
            end
        endcase
    end

    // With HAS_DCACHE set, stall covers the issue cycle so the pipeline never runs ahead
    assign stall = (issue.valid && is_flush && HAS_DCACHE && state == DCFL_IDLE)
        || state != DCFL_IDLE;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= DCFL_IDLE;
            sel <= '0;
            wcnt <= '0;
            mem_wr_valid <= 1'b0;
            mem_wr <= '0;
            done <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            sel <= next_sel;
            wcnt <= next_wcnt;
            mem_wr_valid <= next_mem_wr_valid;
            mem_wr <= next_mem_wr;
            done <= next_done;
        end
    end

    // ----------------------------------------
    // Valid and dirty flags
    // ----------------------------------------
    always_comb begin
        next_valid = valid;
        next_dirty = dirty;
        if (fill_en) begin
            next_valid[fill_line] = 1'b1;
            next_dirty[fill_line] = 1'b0;
        end
        if (store.wr && valid[store.line]) begin
            next_dirty[store.line] = 1'b1;
        end
        if (state == DCFL_INVAL) begin
            next_valid[sel] = 1'b0;
            next_dirty[sel] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            valid <= {LINES{RST_VALID}};
            dirty <= {LINES{RST_DIRTY}};
        end else if (clk_en) begin
            valid <= next_valid;
            dirty <= next_dirty;
        end
    end

    // Arrays carry no reset: contents are meaningless while valid is low
    always_ff @(posedge clock) begin
        if (clk_en && store.wr) begin
            mem_data[{store.line, store.word}] <= store.data;
        end
        if (clk_en && fill_en) begin
            tag[fill_line] <= fill_tag;
        end
    end

    assign line_valid_rd = valid[sel];
    assign line_dirty_rd = dirty[sel];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_inval_clears;
        @(posedge clock) disable iff (!nrst)
        (clk_en && state == DCFL_INVAL) |=> !valid[$past(sel)];
    endproperty
    a_inval_clears: assert property (p_inval_clears) else $error("line still valid");

    property p_dirty_wb;
        @(posedge clock) disable iff (!nrst)
        (clk_en && start && HAS_DCACHE && dirty[line_of(eff_addr)]) |=> mem_wr_valid;
    endproperty
    a_dirty_wb: assert property (p_dirty_wb) else $error("no writeback of dirty line");

    // Once raised, stall may only drop in the cycle that reports completion
    property p_stall_busy;
        @(posedge clock) disable iff (!nrst)
        (clk_en && stall) |=> (stall || done);
    endproperty
    a_stall_busy: assert property (p_stall_busy) else $error("pipeline not held");

    property p_wb_hold;
        @(posedge clock) disable iff (!nrst)
        (clk_en && mem_wr_valid && !mem_wr_ready) |=> (mem_wr_valid && $stable(mem_wr));
    endproperty
    a_wb_hold: assert property (p_wb_hold) else $error("write word dropped before accept");

    property p_clean_skip;
        @(posedge clock) disable iff (!nrst)
        (clk_en && start && HAS_DCACHE && !dirty[line_of(eff_addr)])
            |=> (state == DCFL_INVAL && !mem_wr_valid);
    endproperty
    a_clean_skip: assert property (p_clean_skip) else $error("clean line written back");

    property p_nocache_idle;
        @(posedge clock) disable iff (!nrst)
        !HAS_DCACHE |-> (!mem_wr_valid && !stall);
    endproperty
    a_nocache_idle: assert property (p_nocache_idle) else $error("flush acted without cache");

    property p_sel_index;
        @(posedge clock) disable iff (!nrst)
        (clk_en && start) |=> sel == $past(eff_addr[2+WORD_W +: LINE_W]);
    endproperty
    a_sel_index: assert property (p_sel_index) else $error("wrong line chosen");
endmodule

// [verif/dcfl_mem_model.sv]
`timescale 1ns/1ps
// --------
// Memory side of the write bus; slow mode takes a word every other cycle
// --------
module dcfl_mem_model
    import dcfl_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic slow,
    input wire logic wr_valid,
    input wire dcfl_pkg::dcfl_mem_wr_s wr,
    output logic wr_ready
);
    logic ph;
    dcfl_mem_wr_s log_q[$];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) ph <= 1'b0;
        else ph <= ~ph;
    end
    assign wr_ready = wr_valid && (!slow || ph);
    always @(posedge clock) begin
        if (nrst && wr_valid && wr_ready) log_q.push_back(wr);
    end
endmodule

// [verif/dcfl_top_tb.sv]
`timescale 1ns/1ps
module dcfl_top_tb;
    import dcfl_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic slow = 1'b0;
    dcfl_issue_s issue = '0;
    dcfl_store_s store = '0;
    logic [20:0] fill_tag = '0;
    logic fill_en = 1'b0;
    logic [5:0] fill_line = '0;
    logic stall, done, mwv, mwr, lv, ld, stall2, done2, mwv2;
    dcfl_mem_wr_s mw;
    logic [31:0] ea;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    always #10 clock = ~clock;
    dcfl_top dut (.clock(clock), .nrst(nrst), .clk_en(1'b1), .issue(issue), .store(store),
        .fill_tag(fill_tag), .fill_en(fill_en), .fill_line(fill_line), .stall(stall),
        .done(done), .mem_wr_valid(mwv), .mem_wr_ready(mwr), .mem_wr(mw),
        .line_valid_rd(lv), .line_dirty_rd(ld));
    // No-cache build shares all stimulus except mem_wr_ready, which is tied high
    dcfl_top #(.HAS_DCACHE(1'b0)) dut_nc (.clock(clock), .nrst(nrst), .clk_en(1'b1),
        .issue(issue), .store(store), .fill_tag(fill_tag), .fill_en(fill_en),
        .fill_line(fill_line), .stall(stall2), .done(done2), .mem_wr_valid(mwv2),
        .mem_wr_ready(1'b1), .mem_wr(), .line_valid_rd(), .line_dirty_rd());
    dcfl_mem_model mem (.clock(clock), .nrst(nrst), .slow(slow), .wr_valid(mwv), .wr(mw),
        .wr_ready(mwr));
    // --------
    // Helpers
    // --------
    task automatic tick();
        @(posedge clock);
        #2;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic fill(logic [5:0] ln, logic [20:0] tg);
        fill_en = 1'b1;
        fill_line = ln;
        fill_tag = tg;
        tick();
        fill_en = 1'b0;
    endtask
    // Bounded wait; a hung flush falls out and fails on done
    task automatic flush(logic [31:0] ins, logic [31:0] base, output int cnt);
        issue = '{1'b1, ins, base};
        // Let the combinational stall settle before looking at it
        #1;
        chk(stall, 1);
        chk(stall2, 0);
        tick();
        issue.valid = 1'b0;
        chk(done2, 1);
        cnt = 1;
        while (done !== 1'b1 && cnt < 100) begin
            chk(stall, 1);
            chk(mwv2, 0);
            tick();
            cnt++;
        end
        chk(done, 1);
        chk(stall, 0);
        tick();
        chk(lv, 0);
        chk(ld, 0);
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end
    // --------
    // Scenarios
    // --------
    // Dirty line reached through another tag and a negative offset
    task automatic t_dirty_far_tag();
        slow = 1'b1;
        fill(6'h15, 21'h0abcd);
        for (int w = 0; w < 8; w++) begin
            store = '{1'b1, 6'h15, w[2:0], 32'hd000_0000 + w};
            tick();
        end
        store.wr = 1'b0;
        ea = {21'h01234, 6'h15, 5'h00};
        flush({5'h01, 5'h00, 16'hff9c, OPC_FLUSH_LINE}, ea + 32'd100, n);
        chk(mem.log_q.size(), 8);
        for (int w = 0; w < 8; w++) begin
            chk(mem.log_q[w].addr, {21'h0abcd, 6'h15, w[2:0], 2'b00});
            chk(mem.log_q[w].data, 32'hd000_0000 + w);
        end
    endtask
    // Clean line: no write, done after two cycles
    task automatic t_clean_line();
        mem.log_q.delete();
        slow = 1'b0;
        fill(6'h02, 21'h00001);
        flush({5'h01, 5'h00, 16'h0000, OPC_FLUSH_LINE}, {21'h7, 6'h02, 5'h0}, n);
        chk(n, 2);
        chk(mem.log_q.size(), 0);
    endtask
    // Same flushed line again: dirty state must be gone
    task automatic t_reflush();
        mem.log_q.delete();
        flush({5'h01, 5'h00, 16'h0004, OPC_FLUSH_LINE}, ea, n);
        chk(mem.log_q.size(), 0);
    endtask
    // Other opcode is ignored by both builds
    task automatic t_other_opcode();
        issue = '{1'b1, {5'h01, 5'h00, 16'h0000, 6'h3a}, ea};
        #1;
        chk(stall, 0);
        tick();
        issue.valid = 1'b0;
        chk(done2, 0);
        chk(mwv, 0);
        tick();
        chk(done, 0);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #2 nrst = 1'b1;
        tick();
        t_dirty_far_tag();
        t_clean_line();
        t_reflush();
        t_other_opcode();
        results();
    end
endmodule
